// file: verilog/deac_pkg.sv
// constants and types for the data eeprom access control block
package deac_pkg;
  // clock and self-timed cycle length
  localparam int CLK_PERIOD_NS = 50; // 20 MHz system clock
  localparam int CYCLE_TIME_NS = 2000000; // 2 ms erase or program time
  localparam int CYCLE_CLKS = CYCLE_TIME_NS / CLK_PERIOD_NS; // rounded down
  localparam int CNT_W = 17; // cycle counter width
  // control register field positions
  localparam int CTL_START_BIT = 15; // start bit, hardware clears
  localparam int CTL_PROGRAM_ENABLE_BIT_BIT = 14; // program enable bit
  localparam int CTL_FAULT_BIT = 13; // cycle fault bit
  localparam int CTL_OP_W = 7; // operation code width
  localparam int CTL_GAP_W = 6; // unimplemented bits 12..7
  // operation codes in the low control bits
  localparam logic [6:0] OP_BLOCK_ERASE = 7'h45;
  localparam logic [6:0] OP_WORD_ERASE = 7'h44;
  localparam logic [6:0] OP_WORD_PROG = 7'h04;
  // unlock key values
  localparam logic [15:0] KEY_FIRST = 16'h0055;
  localparam logic [15:0] KEY_SECOND = 16'h00AA;
  // register selects on the cpu write port
  localparam logic [1:0] SEL_CTRL = 2'h0;
  localparam logic [1:0] SEL_ADDR_LO = 2'h1;
  localparam logic [1:0] SEL_ADDR_HI = 2'h2;
  localparam logic [1:0] SEL_KEY = 2'h3;
  // eeprom region and geometry
  localparam logic [7:0] EE_PAGE = 8'h7F; // upper address of the region
  localparam logic [5:0] EE_LO_TOP = 6'h3F; // low address bits 15..10
  localparam int ADDR_HI_W = 7; // implemented upper address bits
  localparam int EE_WORDS = 512; // words of data eeprom
  localparam int IDX_W = 9; // word index width
  localparam int BLK_WORDS = 16; // words in an erase block
  localparam int BLK_W = 4; // index bits inside a block
  localparam logic [15:0] ERASED_WORD = 16'hFFFF; // value after erase
  localparam logic [15:0] BUSY_READ = 16'hFFFF; // read data while busy
  // unlock and cycle sequencer states
  typedef enum logic [3:0] {
    S_IDLE = 4'h1,
    S_KEY1 = 4'h2,
    S_ARMED = 4'h4,
    S_BUSY = 4'h8
  } deac_state_e;
  // complete state of the block
  typedef struct packed {
    deac_state_e state; // sequencer state
    logic program_enable_bit; // program enable bit
    logic fault; // cycle fault bit
    logic [6:0] op; // selected operation
    logic [15:0] addr_lo; // low address register
    logic [6:0] addr_hi; // high address register
    logic [15:0] latch; // write latch
    logic done; // cycle done flag
    logic [CNT_W-1:0] cnt; // cycle timer
    logic [15:0] rd_data; // table read result
    logic rd_valid; // table read answer strobe
  } deac_state_s;
endpackage

// file: verilog/deac_eeprom_ctl.sv
// data eeprom access control: unlock, self-timed erase and program, reads
//
// Overview of operation
// - table read in region returns stored word
// - control 0x4045 selects block erase
// - control 0x4044 selects word erase
// - control 0x4004 selects word program from latch
// - start needs keys 0x55, 0xAA, then start bit
// - cycle self-timed about 2 ms, cpu runs
// - at end clear start, set done flag
// - done flag cleared only by software or reset
// - start blocked while program enable clear
// - program enable untouched at cycle end
// - clearing enable mid-cycle does not abort
// - enable and start in one write refused
// - writing zero to start bit ignored
// - master clear or watchdog reset during cycle sets fault, keeps address
// - read during cycle returns unspecified data
// - enable clear at power-up, timer blocks writes
`timescale 1ns/1ps
module deac_eeprom_ctl
  import deac_pkg::*;
#(
  parameter int CYCLE_LEN = CYCLE_CLKS // cycle length in clocks
)
(
  input wire logic clock, // system clock
  input wire logic rst, // master clear or watchdog reset
  input wire logic por, // power-on reset, clears all registers, array kept
  input wire logic ce, // clock enable, freezes state when low except for resets
  input wire logic pwrt_active, // power-up timer still running
  input wire logic reg_we, // cpu register write strobe
  input wire logic [1:0] reg_sel, // register select
  input wire logic [15:0] reg_wdata, // register write data
  input wire logic tbl_rd, // table read low strobe
  input wire logic tbl_wr, // table write low strobe
  input wire logic [7:0] table_page_pointer, // table page pointer
  input wire logic [15:0] tbl_addr, // table effective address
  input wire logic [15:0] tbl_wdata, // table write data
  input wire logic done_clr, // software clears done flag
  output logic [15:0] eeprom_control_reg, // control register read
  output logic [15:0] eeprom_addr_low_reg, // low address read
  output logic [15:0] eeprom_addr_high_reg, // high address read
  output logic [15:0] rd_data, // table read data
  output logic rd_valid, // table read data valid
  output logic cycle_done_flag, // cycle done flag
  output logic busy // cycle running
);
  deac_state_s s_reg; // registered state
  deac_state_s s_next; // next state
  logic [15:0] mem [EE_WORDS]; // eeprom array
  logic running; // cycle in progress
  logic finish; // last clock of a cycle
  logic tbl_hit; // table address inside eeprom
  logic [IDX_W-1:0] tbl_idx; // word index of table access
  logic [IDX_W-1:0] tgt_idx; // word index of cycle target
  logic ctl_we; // control register write
  logic start_ok; // start request accepted

  // decode helpers
  assign running = (s_reg.state == S_BUSY);
  assign finish = running && (s_reg.cnt == CNT_W'(CYCLE_LEN - 1));
  assign tbl_hit = (table_page_pointer == EE_PAGE) &&
                   (tbl_addr[15:10] == EE_LO_TOP);
  assign tbl_idx = tbl_addr[IDX_W:1];
  assign tgt_idx = s_reg.addr_lo[IDX_W:1];
  assign ctl_we = reg_we && (reg_sel == SEL_CTRL);
  // start only when armed, enabled beforehand, and power-up timer done
  assign start_ok = ctl_we && reg_wdata[CTL_START_BIT] &&
                    (s_reg.state == S_ARMED) &&
                    s_reg.program_enable_bit &&
                    !pwrt_active &&
                    ((reg_wdata[CTL_OP_W-1:0] == OP_BLOCK_ERASE) ||
                     (reg_wdata[CTL_OP_W-1:0] == OP_WORD_ERASE) ||
                     (reg_wdata[CTL_OP_W-1:0] == OP_WORD_PROG));

  // next-state logic
  always_comb
  begin
    s_next = s_reg;
    s_next.rd_valid = 1'b0;
    // cycle timer, stops the cycle on its own
    if (running)
    begin
      s_next.cnt = s_reg.cnt + CNT_W'(1);
      if (finish)
      begin
        s_next.state = S_IDLE; // start bit clears
        s_next.cnt = '0; // program_enable_bit left alone
      end
    end
    // register writes from the cpu
    if (reg_we)
    begin
      case (reg_sel)
        SEL_CTRL:
        begin
          s_next.program_enable_bit = reg_wdata[CTL_PROGRAM_ENABLE_BIT_BIT]; // no abort
          if (!running)
          begin
            s_next.op = reg_wdata[CTL_OP_W-1:0];
            s_next.fault = reg_wdata[CTL_FAULT_BIT];
            if (start_ok)
            begin
              s_next.state = S_BUSY;
              s_next.cnt = '0;
            end
            else
              s_next.state = S_IDLE;
          end
          // zero to the start bit cannot stop a cycle
        end
        SEL_ADDR_LO:
        begin
          if (!running)
          begin
            s_next.addr_lo = reg_wdata;
            s_next.state = S_IDLE;
          end
        end
        SEL_ADDR_HI:
        begin
          if (!running)
          begin
            s_next.addr_hi = reg_wdata[ADDR_HI_W-1:0];
            s_next.state = S_IDLE;
          end
        end
        SEL_KEY:
        begin
          if (!running)
          begin
            if (reg_wdata == KEY_FIRST)
              s_next.state = S_KEY1;
            else if (reg_wdata == KEY_SECOND && s_reg.state == S_KEY1)
              s_next.state = S_ARMED;
            else
              s_next.state = S_IDLE; // wrong key
          end
        end
        default: s_next.state = s_reg.state; // full decode, never taken
      endcase
    end
    // table write fills the latch and captures the address
    if (tbl_wr && tbl_hit && !running)
    begin
      s_next.latch = tbl_wdata;
      s_next.addr_lo = tbl_addr;
      s_next.addr_hi = table_page_pointer[ADDR_HI_W-1:0];
    end
    // table read answers one clock later
    if (tbl_rd)
    begin
      s_next.rd_valid = 1'b1;
      if (!tbl_hit)
        s_next.rd_data = '0; // outside the eeprom
      else if (running)
        s_next.rd_data = BUSY_READ;
      else
        s_next.rd_data = mem[tbl_idx];
    end
    // done flag: a finishing cycle beats a software clear
    s_next.done = finish || (s_reg.done && !done_clr);
    // resets
    if (por)
    begin
      s_next = '0; // program_enable_bit clear at power-up
      s_next.state = S_IDLE;
    end
    else if (rst)
    begin
      s_next.fault = s_reg.fault || running; // address kept
      s_next.state = S_IDLE;
      s_next.program_enable_bit = 1'b0;
      s_next.op = '0;
      s_next.done = 1'b0;
      s_next.cnt = '0;
      s_next.rd_valid = 1'b0;
    end
  end

  // state register, frozen while ce low except for resets
  always_ff @(posedge clock)
  begin
    if (ce || rst || por)
      s_reg <= s_next;
  end

  // array update at the end of a cycle
  always_ff @(posedge clock)
  begin
    if (ce && !rst && !por && finish)
    begin
      case (s_reg.op)
        OP_BLOCK_ERASE:
        begin
          for (int i = 0; i < BLK_WORDS; i++)
            mem[{tgt_idx[IDX_W-1:BLK_W], BLK_W'(i)}] <= ERASED_WORD;
        end
        OP_WORD_ERASE: mem[tgt_idx] <= ERASED_WORD;
        OP_WORD_PROG: mem[tgt_idx] <= s_reg.latch;
        default: mem[tgt_idx] <= mem[tgt_idx]; // other codes never start
      endcase
    end
  end

  // outputs
  assign busy = running;
  assign eeprom_control_reg = {running, s_reg.program_enable_bit, s_reg.fault,
                               {CTL_GAP_W{1'b0}}, s_reg.op};
  assign eeprom_addr_low_reg = s_reg.addr_lo;
  assign eeprom_addr_high_reg = {{(16-ADDR_HI_W){1'b0}}, s_reg.addr_hi};
  assign rd_data = s_reg.rd_data;
  assign rd_valid = s_reg.rd_valid;
  assign cycle_done_flag = s_reg.done;

  // checks
  property p_rd_ans;
    @(posedge clock) disable iff (rst || por)
    ce && tbl_rd |=> rd_valid;
  endproperty
  a_rd_ans: assert property (p_rd_ans) else $error("no read answer");
  property p_no_program_enable_bit;
    @(posedge clock) disable iff (rst || por)
    ce && ctl_we && !s_reg.program_enable_bit && !busy |=> !busy;
  endproperty
  a_no_program_enable_bit: assert property (p_no_program_enable_bit) else $error("no-en start");
  property p_same_wr;
    @(posedge clock) disable iff (rst || por)
    ce && ctl_we && reg_wdata[CTL_START_BIT] && reg_wdata[CTL_PROGRAM_ENABLE_BIT_BIT]
      && !s_reg.program_enable_bit && !busy |=> !busy;
  endproperty
  a_same_wr: assert property (p_same_wr) else $error("joint start");
  property p_armed;
    @(posedge clock) disable iff (rst || por)
    $rose(busy) |-> $past(s_reg.state) == S_ARMED;
  endproperty
  a_armed: assert property (p_armed) else $error("start without keys");
  property p_done_set;
    @(posedge clock) disable iff (rst || por)
    $fell(busy) && !$past(rst) |-> cycle_done_flag;
  endproperty
  a_done_set: assert property (p_done_set) else $error("done not set");
  property p_sticky;
    @(posedge clock) disable iff (rst || por)
    cycle_done_flag && !(ce && done_clr) |=> cycle_done_flag;
  endproperty
  a_sticky: assert property (p_sticky) else $error("done lost");
  property p_program_enable_bit_kept;
    @(posedge clock) disable iff (rst || por)
    busy && finish && ce && !reg_we |=> s_reg.program_enable_bit == $past(s_reg.program_enable_bit);
  endproperty
  a_program_enable_bit_kept: assert property (p_program_enable_bit_kept) else $error("program_enable_bit flip");
  property p_no_abort;
    @(posedge clock) disable iff (rst || por)
    busy && !finish |=> busy;
  endproperty
  a_no_abort: assert property (p_no_abort) else $error("aborted");
  property p_len;
    @(posedge clock) disable iff (rst || por)
    $rose(busy) |-> busy [*8];
  endproperty
  a_len: assert property (p_len) else $error("cycle too short");
  property p_fault;
    @(posedge clock) disable iff (por)
    rst && busy |=> s_reg.fault && !busy &&
      eeprom_addr_low_reg == $past(eeprom_addr_low_reg);
  endproperty
  a_fault: assert property (p_fault) else $error("fault not set");
  property p_busy_rd;
    @(posedge clock) disable iff (rst || por)
    ce && tbl_rd && tbl_hit && busy |=> rd_data == BUSY_READ;
  endproperty
  a_busy_rd: assert property (p_busy_rd) else $error("busy read");
  property p_pwrt;
    @(posedge clock) disable iff (rst || por)
    pwrt_active && !busy |=> !busy;
  endproperty
  a_pwrt: assert property (p_pwrt) else $error("start in power-up");
  property p_cancel;
    @(posedge clock) disable iff (rst || por)
    ce && reg_we && reg_sel != SEL_KEY && !ctl_we && !busy
      |=> s_reg.state == S_IDLE;
  endproperty
  a_cancel: assert property (p_cancel) else $error("unlock kept");
endmodule

// file: dv/deac_eeprom_ctl_bench.sv
// self-checking bench for the data eeprom access control block
`timescale 1ns/1ps
module deac_eeprom_ctl_bench
  import deac_pkg::*;
;
  localparam int CL = 20; // shortened cycle length
  logic clock = 1'b0; // system clock
  logic rst = 1'b1; // master clear
  logic por = 1'b1; // power-on reset
  logic ce = 1'b1; // clock enable, held on except five edges in the block erase
  logic pwrt_active = 1'b0; // power-up timer
  logic reg_we = 1'b0; // register write strobe
  logic [1:0] reg_sel = 2'h0; // register select
  logic [15:0] reg_wdata = 16'h0000; // register data
  logic tbl_rd = 1'b0; // table read strobe
  logic tbl_wr = 1'b0; // table write strobe
  logic [7:0] table_page_pointer = 8'h00; // table page
  logic [15:0] tbl_addr = 16'h0000; // table address
  logic [15:0] tbl_wdata = 16'h0000; // table data
  logic done_clr = 1'b0; // done flag clear
  logic [15:0] ctl_q; // control register view
  logic [15:0] alo_q; // low address view
  logic [15:0] ahi_q; // high address view
  logic [15:0] rd_data; // read data
  logic rd_valid; // read strobe
  logic cycle_done_flag; // done flag
  logic busy; // cycle running
  int mismatches = 0; // failed compares
  int comparisons = 0; // all compares
  integer seed = 61194; // random seed
  logic [15:0] exp_q[$]; // expected read words
  logic [8:0] ia; // first word index
  logic [8:0] ib; // word in another block
  logic [15:0] da; // first data word
  logic [15:0] db; // second data word
  logic [15:0] abk; // block erase address

  // clock generator, 50 ns period
  always #25 clock = ~clock;

  deac_eeprom_ctl #(.CYCLE_LEN(CL)) uut (.clock(clock), .rst(rst),
    .por(por), .ce(ce), .pwrt_active(pwrt_active), .reg_we(reg_we),
    .reg_sel(reg_sel), .reg_wdata(reg_wdata), .tbl_rd(tbl_rd),
    .tbl_wr(tbl_wr), .table_page_pointer(table_page_pointer),
    .tbl_addr(tbl_addr), .tbl_wdata(tbl_wdata), .done_clr(done_clr),
    .eeprom_control_reg(ctl_q), .eeprom_addr_low_reg(alo_q),
    .eeprom_addr_high_reg(ahi_q), .rd_data(rd_data), .rd_valid(rd_valid),
    .cycle_done_flag(cycle_done_flag), .busy(busy));

  // compare and count
  task automatic chk(input string nm, input logic [15:0] s,
    input logic [15:0] e);
    comparisons++;
    if (s !== e)
    begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask

  // verdict and end of run
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // eeprom table address of a word index
  function automatic logic [15:0] ea(input logic [8:0] ix);
    return {EE_LO_TOP, ix, 1'b0};
  endfunction

  // one register write, outputs settled on return
  task automatic wr(input logic [1:0] sel, input logic [15:0] d);
    @(posedge clock);
    reg_we <= 1'b1;
    reg_sel <= sel;
    reg_wdata <= d;
    @(posedge clock);
    reg_we <= 1'b0;
    #1;
  endtask

  // table read, expected word noted for the monitor
  task automatic rd(input logic [7:0] pg, input logic [15:0] a,
    input logic [15:0] e);
    @(posedge clock);
    tbl_rd <= 1'b1;
    table_page_pointer <= pg;
    tbl_addr <= a;
    exp_q.push_back(e);
    @(posedge clock);
    tbl_rd <= 1'b0;
    #1;
  endtask

  // table write into the latch
  task automatic twr(input logic [15:0] a, input logic [15:0] d);
    @(posedge clock);
    tbl_wr <= 1'b1;
    table_page_pointer <= EE_PAGE;
    tbl_addr <= a;
    tbl_wdata <= d;
    @(posedge clock);
    tbl_wr <= 1'b0;
    #1;
  endtask

  // setup, two keys, optional stray write, then start
  task automatic attempt(input logic [15:0] cs, input logic [15:0] k1,
    input logic [15:0] k2, input logic mid, input logic [15:0] cg,
    input logic eb);
    wr(SEL_CTRL, cs);
    wr(SEL_KEY, k1); // keys back to back, nothing between
    wr(SEL_KEY, k2);
    if (mid)
      wr(SEL_ADDR_HI, 16'h007F);
    wr(SEL_CTRL, cg);
    chk("busy_start", {15'h0, busy}, {15'h0, eb});
  endtask

  // bounded wait for cycle end, length checked when n_exp >= 0
  task automatic wait_done(input int n_exp);
    int n;
    n = 0;
    while (busy === 1'b1 && n < 200)
    begin
      @(posedge clock);
      #1;
      n++;
    end
    if (n_exp >= 0)
      chk("cycle_len", n[15:0], n_exp[15:0]);
    chk("done_set", {15'h0, cycle_done_flag}, 16'h0001);
    chk("start_clr", {15'h0, ctl_q[15]}, 16'h0000);
  endtask

  // software clear of the done flag
  task automatic clr_done();
    chk("done_held", {15'h0, cycle_done_flag}, 16'h0001);
    @(posedge clock);
    done_clr <= 1'b1;
    @(posedge clock);
    done_clr <= 1'b0;
    #1;
    chk("done_clr", {15'h0, cycle_done_flag}, 16'h0000);
  endtask

  // erase a word, latch data, program it, read back
  task automatic update(input logic [8:0] ix, input logic [15:0] d);
    wr(SEL_ADDR_HI, 16'h007F);
    wr(SEL_ADDR_LO, ea(ix));
    chk("addr_hi", ahi_q, 16'h007F);
    chk("addr_lo", alo_q, ea(ix));
    attempt(16'h4044, KEY_FIRST, KEY_SECOND, 1'b0, 16'hC044, 1'b1);
    chk("ctl_erase", ctl_q, 16'hC044);
    wait_done(CL);
    chk("program_enable_bit_kept", ctl_q, 16'h4044);
    rd(EE_PAGE, ea(ix), ERASED_WORD);
    clr_done();
    twr(ea(ix), d);
    attempt(16'h4004, KEY_FIRST, KEY_SECOND, 1'b0, 16'hC004, 1'b1);
    rd(EE_PAGE, ea(ix), BUSY_READ);
    wait_done(-1);
    rd(EE_PAGE, ea(ix), d);
    clr_done();
    // enable dropped again once the update is over
    wr(SEL_CTRL, 16'h0000);
    chk("program_enable_bit_idle", ctl_q, 16'h0000);
  endtask

  // monitor: each read answer against the oldest note
  always @(posedge clock)
  begin
    if (rd_valid === 1'b1)
    begin
      if (exp_q.size() == 0)
        chk("rd_unexpected", 16'h0000, 16'h0001);
      else
        chk("rd_data", rd_data, exp_q.pop_front());
    end
  end

  // watchdog against a hang
  initial
  begin
    repeat (5000) @(posedge clock);
    mismatches++;
    stop_test();
  end

  // main sequence
  initial
  begin
    repeat (20) @(posedge clock);
    rst <= 1'b0;
    por <= 1'b0;
    @(posedge clock);
    #1;
    chk("ctl_reset", ctl_q, 16'h0000);
    ia = 9'($random(seed));
    ib = ia ^ 9'h010;
    da = 16'($random(seed));
    db = 16'($random(seed));
    update(ia, da);
    update(ib, db);
    // refused starts
    attempt(16'h0044, KEY_FIRST, KEY_SECOND, 1'b0, 16'h8044, 1'b0);
    attempt(16'h0044, KEY_FIRST, KEY_SECOND, 1'b0, 16'hC044, 1'b0);
    attempt(16'h4044, KEY_SECOND, KEY_FIRST, 1'b0, 16'hC044, 1'b0);
    attempt(16'h4044, KEY_FIRST, KEY_SECOND, 1'b1, 16'hC044, 1'b0);
    @(posedge clock);
    pwrt_active <= 1'b1;
    attempt(16'h4044, KEY_FIRST, KEY_SECOND, 1'b0, 16'hC044, 1'b0);
    @(posedge clock);
    pwrt_active <= 1'b0;
    rd(8'h00, ea(ia), 16'h0000);
    // enable dropped and zero start written mid-cycle
    attempt(16'h4004, KEY_FIRST, KEY_SECOND, 1'b0, 16'hC004, 1'b1);
    wr(SEL_CTRL, 16'h0004);
    chk("busy_held", {15'h0, busy}, 16'h0001);
    wait_done(CL - 2);
    chk("program_enable_bit_off", ctl_q, 16'h0004);
    clr_done();
    rd(EE_PAGE, ea(ib), db);
    // block erase of the first word's block
    abk = ea({ia[8:4], ~ia[3:0]});
    wr(SEL_ADDR_HI, 16'h007F);
    wr(SEL_ADDR_LO, abk);
    attempt(16'h4045, KEY_FIRST, KEY_SECOND, 1'b0, 16'hC045, 1'b1);
    chk("ctl_block", ctl_q, 16'hC045);
    // clock enable low for five edges stretches the cycle by five
    @(posedge clock);
    ce <= 1'b0;
    repeat (5) @(posedge clock);
    ce <= 1'b1;
    wait_done(CL - 1); // 25 busy edges, 6 already spent
    rd(EE_PAGE, ea(ia), ERASED_WORD);
    rd(EE_PAGE, ea(ib), db);
    clr_done();
    // reset in mid-cycle
    attempt(16'h4044, KEY_FIRST, KEY_SECOND, 1'b0, 16'hC044, 1'b1);
    @(posedge clock);
    rst <= 1'b1;
    @(posedge clock);
    rst <= 1'b0;
    #1;
    chk("ctl_fault", ctl_q, 16'h2000);
    chk("addr_kept", alo_q, abk);
    chk("busy_rst", {15'h0, busy}, 16'h0000);
    chk("addr_hi_kept", ahi_q, 16'h007F);
    // one more edge so the reset check in the design is evaluated
    @(posedge clock);
    #1;
    chk("fault_held", ctl_q, 16'h2000);
    stop_test();
  end
endmodule
